//--- common/acc_pkg.sv
package acc_pkg;
  // ==========================================================
  // register layout
  localparam int unsigned ENABLE_BIT  = 7;
  localparam int unsigned REFSEL_BIT  = 6;
  localparam int unsigned FLAG_BIT    = 5;
  localparam int unsigned IRQEN_BIT   = 4;
  localparam int unsigned RESULT_BIT  = 3;
  localparam int unsigned PINEN_BIT   = 2;
  localparam int unsigned MODE_HI_BIT = 1;
  localparam int unsigned MODE_LO_BIT = 0;
  localparam logic [7:0]  CSR_RESET   = 8'h00;

  // ==========================================================
  // edge mode encodings
  localparam logic [1:0] MODE_FALL0 = 2'h0;
  localparam logic [1:0] MODE_RISE  = 2'h1;
  localparam logic [1:0] MODE_FALL2 = 2'h2;
  localparam logic [1:0] MODE_BOTH  = 2'h3;

  // ==========================================================
  // register access carrier
  typedef struct packed {
    logic       wr;
    logic [7:0] wdata;
  } acc_wr_t;

  // analog side controls
  typedef struct packed {
    logic enable;
    logic ref_select;
  } acc_ana_t;
endpackage

//--- hdl/acc_edge.sv
`timescale 1ns/1ns
// ==========================================================
// synchroniser and edge detector for the comparator result
module acc_edge (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       clr_i,
  input  wire logic       raw_i,
  input  wire logic [1:0] mode_i,
  output logic            level_o,
  output logic            event_o
);
  import acc_pkg::*;

  logic meta;
  logic sync;
  logic prev;

  // two stage sync, then one history stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else if (clr_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= raw_i;
      sync <= meta;
      prev <= sync;
    end
  end

  // compare successive synchronised samples
  wire rise = sync & ~prev;
  wire fall = ~sync & prev;
  wire hit  = (mode_i == MODE_RISE) ? rise :
              (mode_i == MODE_BOTH) ? (rise | fall) : fall;

  assign level_o = sync;
  assign event_o = hit;
endmodule // acc_edge

//--- hdl/acc_top.sv
`timescale 1ns/1ns
module acc_top
  import acc_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  input  wire logic          deep_stop_wake_i,
  input  wire acc_pkg::acc_wr_t csr_wr_i,
  input  wire logic          comparator_result_i,
  output acc_pkg::acc_ana_t  ana_ctrl_o,
  output logic [7:0]         csr_rdata_o,
  output logic               irq_o,
  output logic               wake_o,
  output logic               comparator_output_pin_o,
  output logic               comparator_output_pin_oe_o
);
  import acc_pkg::*;

  // ==========================================================
  // control state
  logic       enable;
  logic       ref_select;
  logic       flag;
  logic       irq_en;
  logic       pin_en;
  logic [1:0] edge_mode;
  logic       sync_level;
  logic       evt;

  // analog compare itself lives in the analog macro: result_i is
  // high when non-inverting exceeds inverting
  wire disabled = ~enable;

  // synchroniser held cleared while disabled, so no stale edge fires
  acc_edge u_edge (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .clr_i   (disabled),
    .raw_i   (comparator_result_i),
    .mode_i  (edge_mode),
    .level_o (sync_level),
    .event_o (evt)
  );
  // edge search on synchronised samples

  // ==========================================================
  // write decode
  wire       wr        = csr_wr_i.wr;
  wire [7:0] wd        = csr_wr_i.wdata;
  wire       flag_clr  = wr & wd[FLAG_BIT];
  wire       flag_set  = evt & enable;
  wire       next_flag = flag_set | (flag & ~flag_clr);
  // set wins over a clear in the same cycle, so no event is lost

  // control bits; deep stop wake acts like a reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable     <= CSR_RESET[ENABLE_BIT];
      ref_select <= CSR_RESET[REFSEL_BIT];
      irq_en     <= CSR_RESET[IRQEN_BIT];
      pin_en     <= CSR_RESET[PINEN_BIT];
      edge_mode  <= CSR_RESET[MODE_HI_BIT:MODE_LO_BIT];
    end else if (deep_stop_wake_i) begin
      enable     <= CSR_RESET[ENABLE_BIT];
      ref_select <= CSR_RESET[REFSEL_BIT];
      irq_en     <= CSR_RESET[IRQEN_BIT];
      pin_en     <= CSR_RESET[PINEN_BIT];
      edge_mode  <= CSR_RESET[MODE_HI_BIT:MODE_LO_BIT];
    end else if (wr) begin
      enable     <= wd[ENABLE_BIT];
      ref_select <= wd[REFSEL_BIT];
      irq_en     <= wd[IRQEN_BIT];
      pin_en     <= wd[PINEN_BIT];
      edge_mode  <= wd[MODE_HI_BIT:MODE_LO_BIT];
    end
  end

  // flag; no stop or debug gating
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag <= CSR_RESET[FLAG_BIT];
    end else if (deep_stop_wake_i) begin
      flag <= CSR_RESET[FLAG_BIT];
    end else begin
      flag <= next_flag;
    end
  end

  // ==========================================================
  // outputs, all registered
  wire [7:0] next_rdata = {enable, ref_select, next_flag, irq_en,
                           enable & sync_level, pin_en, edge_mode};
  // result bit reads zero while disabled
  wire next_irq   = next_flag & irq_en;
  // deep stop wake drops the pin at once, matching the cleared register
  wire next_pin   = pin_en & enable & sync_level & ~deep_stop_wake_i;
  wire next_pinoe = pin_en & enable & ~deep_stop_wake_i;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      csr_rdata_o                <= CSR_RESET;
      irq_o                      <= 1'b0;
      wake_o                     <= 1'b0;
      comparator_output_pin_o    <= 1'b0;
      comparator_output_pin_oe_o <= 1'b0;
      ana_ctrl_o                 <= '0;
    end else begin
      csr_rdata_o                <= deep_stop_wake_i ? CSR_RESET
                                                     : next_rdata;
      irq_o                      <= next_irq & ~deep_stop_wake_i;
      wake_o                     <= next_irq & ~deep_stop_wake_i;
      comparator_output_pin_o    <= next_pin;
      comparator_output_pin_oe_o <= next_pinoe;
      ana_ctrl_o.enable          <= enable & ~deep_stop_wake_i;
      ana_ctrl_o.ref_select      <= ref_select & ~deep_stop_wake_i;
    end
  end
  // note: edge sync adds two cycles of latency; accepted for safety
  // against metastability from the asynchronous analog output
endmodule // acc_top

//--- test/acc_analog.sv
`timescale 1ns/1ns
// ==========================
// behavioural comparator and its input selector
module acc_analog (
  input  wire logic       en_i,
  input  wire logic       refsel_i,
  input  wire logic [7:0] pos_i,
  input  wire logic [7:0] neg_i,
  input  wire logic [7:0] bg_i,
  output logic            out_o
);
  // unpowered reads low; a tie also reads low
  wire logic [7:0] vin = refsel_i ? bg_i : pos_i;
  assign out_o = en_i && (vin > neg_i);
endmodule // acc_analog

//--- test/acc_checker.sv
`timescale 1ns/1ns
// ==========================
// port checks for the comparator control
module acc_checker
  import acc_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic              deep_stop_wake_i,
  input wire acc_pkg::acc_wr_t  csr_wr_i,
  input wire logic              comparator_result_i,
  input wire acc_pkg::acc_ana_t ana_ctrl_o,
  input wire logic [7:0]        csr_rdata_o,
  input wire logic              irq_o,
  input wire logic              wake_o,
  input wire logic              comparator_output_pin_o,
  input wire logic              comparator_output_pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic [7:0] r = csr_rdata_o;
  wire logic wn = csr_wr_i.wr && !deep_stop_wake_i;
  logic [3:0] q; // age of raw input, saturating
  // ages the raw input so flag changes can be tied to it
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) q <= 4'h0;
    else if ($changed(comparator_result_i)) q <= 4'h0;
    else if (q != 4'hF) q <= q + 4'h1;
  sequence s_ev; $rose(r[5]); endsequence
  sequence s_clr; wn && csr_wr_i.wdata[5] && q > 4'h9; endsequence
  a_enable_bit: assert property (ana_ctrl_o.enable == r[7]) else $error("en");
  a_ref_bit: assert property (ana_ctrl_o.ref_select == r[6]) else $error("ref");
  a_flag_cause: assert property (s_ev |-> q < 4'h7) else $error("ev");
  sequence s_wr; wn ##1 !deep_stop_wake_i; endsequence
  a_flag_keep: assert property (
    wn && !csr_wr_i.wdata[5] && r[5] |=> r[5]) else $error("keep");
  a_flag_clear: assert property (s_clr |=> !r[5]) else $error("clr");
  a_irq_level: assert property (irq_o == (r[5] && r[4])) else $error("irq");
  a_wake_irq: assert property (wake_o == irq_o) else $error("wake");
  a_result_off: assert property (
    !r[7] && $past(!r[7]) |-> !r[3]) else $error("off");
  a_pin_enable: assert property (
    comparator_output_pin_oe_o == (r[2] && r[7])) else $error("oe");
  a_pin_value: assert property (
    comparator_output_pin_oe_o |-> comparator_output_pin_o == r[3])
    else $error("pin");
  a_deep_clear: assert property (
    deep_stop_wake_i |=> r == 8'h00 && !irq_o) else $error("deep");
  // fields land one edge after the write, read back one edge later
  a_write_load: assert property (s_wr |=>
    {r[7:6], r[4], r[2:0]} == $past({csr_wr_i.wdata[7:6],
    csr_wr_i.wdata[4], csr_wr_i.wdata[2:0]}, 2)) else $error("wr");
endmodule // acc_checker
bind acc_top acc_checker u_chk (.*);

//--- test/acc_top_test.sv
`timescale 1ns/1ns
// ==========================
// bench for the comparator control
module acc_top_test;
  import acc_pkg::*;
  localparam logic [7:0] BG = 8'h80; // bandgap level in model units
  logic clk_i, rstn_i, deep, res, irq, wake, pin, oe;
  logic [7:0] pos, neg, r, c;
  acc_wr_t w;
  acc_ana_t ana;
  int n_fail, samples_checked, cyc;
  integer seed = 32'h4d5a;
  acc_analog u_ana (.en_i(ana.enable), .refsel_i(ana.ref_select),
    .pos_i(pos), .neg_i(neg), .bg_i(BG), .out_o(res));
  acc_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .deep_stop_wake_i(deep),
    .csr_wr_i(w), .comparator_result_i(res), .ana_ctrl_o(ana),
    .csr_rdata_o(r), .irq_o(irq), .wake_o(wake),
    .comparator_output_pin_o(pin), .comparator_output_pin_oe_o(oe));
  // clock and hang guard
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      stop_test;
    end
  end
  // ==========================
  // helpers
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] d);
    w = '{1'b1, d};
    @(negedge clk_i) w.wr = 1'b0;
  endtask
  task automatic tk(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic ex(logic [7:0] k, logic [7:0] p, logic [7:0] n);
    return k[7] && ((k[6] ? BG : p) > n);
  endfunction
  // ==========================
  // edge modes, then random compares, then deep stop wake
  initial begin
    rstn_i = 0; deep = 0; w = '0; pos = 8'h10; neg = 8'h40;
    tk(3);
    rstn_i = 1;
    chk("rst", CSR_RESET, r);
    for (int m = 0; m < 4; m++) begin
      wr(8'h94 | 8'(m)); pos = 8'h10; tk(6); wr(8'hB4 | 8'(m));
      pos = 8'h70; tk(6);
      chk("rise", {6'h0, m[0], m[0]}, {6'h0, r[5], irq});
      chk("out", 8'h07, {5'h0, pin, oe, r[3]});
      wr(8'h94 | 8'(m)); tk(1); chk("keep", m[0], r[5]);
      wr(8'hB4 | 8'(m)); pos = 8'h10; tk(6);
      chk("fall", m != 1, r[5]);
    end
    for (int i = 0; i < 24; i++) begin
      c = $random(seed); pos = $random(seed); neg = $random(seed);
      wr(c); tk(5);
      chk("cmp", ex(c, pos, neg), r[3]);
    end
    wr(8'hD7); deep = 1; tk(1); deep = 0; tk(1);
    chk("deep", 8'h00, r);
    stop_test;
  end
endmodule // acc_top_test
